// ### src/ppmm_top.sv
`default_nettype none
// How it works
// - The four select inputs alone decide how all 32 port lanes are read.
// - Select 0000 splits lanes into data high, data low, address and control bytes.
// - Select 0001 uses only low lanes as serial clock, data, select and sync.
// - Select 0010 loads the whole frequency word straight from the port.
// - Select 0011 loads the frequency word with its two halves swapped.
// - Select 0100 loads phase from bits 31:16 and amplitude from bits 11:0.
// - Select 0101 loads amplitude from bits 27:16 and phase from bits 15:0.
// - Selects 0110 to 1001 load frequency 31:8 plus one amplitude or phase byte.
// - Selects 1010 to 1101 load frequency 23:0 plus one amplitude or phase byte.
// - Port amplitude reaches the output only while amplitude scaling is enabled.
// - Selects 1110 and 1111 load nothing; like every select except 0001, they clear o_serial_active.
// - Only amplitude bits 11:0 take effect; bits 15:12 are dropped.
// - Streaming sends values on at once; otherwise they wait for the update strobe.
// - Port and select inputs are sampled once every 24 clock cycles.
module ppmm_top (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_func_sel,
  input wire logic [31:0] i_port,
  input wire logic i_amp_scale_enable,
  input wire logic i_stream_enable,
  input wire logic i_io_update,
  output logic o_par_valid,
  input wire logic i_par_ready,
  output ppmm_pkg::ppmm_par_word_t o_par_word,
  output ppmm_pkg::ppmm_serial_t o_serial,
  output logic o_serial_active,
  output ppmm_pkg::ppmm_params_t o_core_params,
  output logic o_core_load,
  output logic o_sample_dropped
);
  localparam int SAMPLE_W = $bits(ppmm_pkg::ppmm_sample_t);

  logic tick;
  ppmm_pkg::ppmm_sample_t sample;
  logic [SAMPLE_W-1:0] fifo_out;
  logic fifo_valid;
  logic fifo_in_ready;
  logic fifo_pop;
  ppmm_pkg::ppmm_sample_t head;
  ppmm_pkg::ppmm_params_t held;
  ppmm_pkg::ppmm_params_t next_held;
  ppmm_pkg::ppmm_params_t next_core;
  ppmm_pkg::ppmm_par_word_t next_par_word;
  ppmm_pkg::ppmm_serial_t next_serial;
  logic next_par_valid;
  logic next_serial_active;
  logic next_core_load;
  logic next_dropped;
  logic par_pending;
  logic direct_hit;

  ppmm_rate_div u_div (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .o_tick(tick)
  );

  // The select and lanes are captured together so each word carries its mode.
  assign sample.mode = ppmm_pkg::ppmm_mode_t'(i_func_sel);
  assign sample.lanes = i_port;

  ppmm_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(ppmm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_in_valid(tick),
    .o_in_ready(fifo_in_ready),
    .i_in_data(sample),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out)
  );

  assign head = ppmm_pkg::ppmm_sample_t'(fifo_out);
  // A parallel programming word waits while its consumer stalls; this backs up the FIFO.
  assign par_pending = o_par_valid && !i_par_ready;
  assign fifo_pop = fifo_valid && !par_pending;

  function automatic logic [15:0] amp_clip(input logic [15:0] a);
    amp_clip = a & ppmm_pkg::AMP_LIVE_MASK;
  endfunction

  always_comb begin
    next_held = held;
    next_par_word = o_par_word;
    next_par_valid = par_pending;
    next_serial = o_serial;
    next_serial_active = o_serial_active;
    direct_hit = 1'b0;
    if (fifo_pop) begin
      next_serial_active = 1'b0;
      unique case (head.mode)
        ppmm_pkg::PPMM_PAR_PROG: begin
          next_par_word = ppmm_pkg::ppmm_par_word_t'(head.lanes);
          next_par_valid = 1'b1;
        end
        ppmm_pkg::PPMM_SER_PROG: begin
          next_serial = ppmm_pkg::ppmm_serial_t'(head.lanes[4:0]);
          next_serial_active = 1'b1;
        end
        ppmm_pkg::PPMM_FREQ_FULL: begin
          next_held.freq_tuning_word = head.lanes;
          direct_hit = 1'b1;
        end
        ppmm_pkg::PPMM_FREQ_SWAP: begin
          next_held.freq_tuning_word = {head.lanes[15:0], head.lanes[31:16]};
          direct_hit = 1'b1;
        end
        ppmm_pkg::PPMM_PHASE_AMP: begin
          next_held.phase_offset_word = head.lanes[31:16];
          next_held.amplitude_word[11:0] = head.lanes[11:0];
          direct_hit = 1'b1;
        end
        ppmm_pkg::PPMM_AMP_PHASE: begin
          next_held.amplitude_word[11:0] = head.lanes[27:16];
          next_held.phase_offset_word = head.lanes[15:0];
          direct_hit = 1'b1;
        end
        ppmm_pkg::PPMM_FHI_AMPHI, ppmm_pkg::PPMM_FHI_PHHI,
        ppmm_pkg::PPMM_FHI_AMPLO, ppmm_pkg::PPMM_FHI_PHLO: begin
          next_held.freq_tuning_word[31:8] = head.lanes[31:8];
          direct_hit = 1'b1;
        end
        ppmm_pkg::PPMM_FLO_AMPHI, ppmm_pkg::PPMM_FLO_PHHI,
        ppmm_pkg::PPMM_FLO_AMPLO, ppmm_pkg::PPMM_FLO_PHLO: begin
          next_held.freq_tuning_word[23:0] = head.lanes[31:8];
          direct_hit = 1'b1;
        end
        ppmm_pkg::PPMM_UNUSED_E, ppmm_pkg::PPMM_UNUSED_F: begin
          direct_hit = 1'b0;
        end
      endcase
      // Low byte routing for the partial modes, shared by both frequency groups.
      unique case (head.mode)
        ppmm_pkg::PPMM_FHI_AMPHI, ppmm_pkg::PPMM_FLO_AMPHI:
          next_held.amplitude_word[15:8] = head.lanes[7:0];
        ppmm_pkg::PPMM_FHI_PHHI, ppmm_pkg::PPMM_FLO_PHHI:
          next_held.phase_offset_word[15:8] = head.lanes[7:0];
        ppmm_pkg::PPMM_FHI_AMPLO, ppmm_pkg::PPMM_FLO_AMPLO:
          next_held.amplitude_word[7:0] = head.lanes[7:0];
        ppmm_pkg::PPMM_FHI_PHLO, ppmm_pkg::PPMM_FLO_PHLO:
          next_held.phase_offset_word[7:0] = head.lanes[7:0];
        default: begin
        end
      endcase
    end
    next_dropped = tick && !fifo_in_ready;
  end

  always_comb begin
    next_core = o_core_params;
    next_core_load = 1'b0;
    if ((i_stream_enable && direct_hit) || i_io_update) begin
      next_core.freq_tuning_word = next_held.freq_tuning_word;
      next_core.phase_offset_word = next_held.phase_offset_word;
      if (i_amp_scale_enable) begin
        next_core.amplitude_word = amp_clip(next_held.amplitude_word);
      end
      next_core_load = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      held <= {ppmm_pkg::FREQ_RST, ppmm_pkg::PHASE_RST, ppmm_pkg::AMP_RST};
      o_core_params <= {ppmm_pkg::FREQ_RST, ppmm_pkg::PHASE_RST, ppmm_pkg::AMP_RST};
      o_core_load <= 1'b0;
      o_par_word <= '0;
      o_par_valid <= 1'b0;
      o_serial <= '0;
      o_serial_active <= 1'b0;
      o_sample_dropped <= 1'b0;
    end else begin
      held <= next_held;
      o_core_params <= next_core;
      o_core_load <= next_core_load;
      o_par_word <= next_par_word;
      o_par_valid <= next_par_valid;
      o_serial <= next_serial;
      o_serial_active <= next_serial_active;
      o_sample_dropped <= next_dropped;
    end
  end
endmodule
`default_nettype wire

// ### shared/ppmm_pkg.sv
`default_nettype none
package ppmm_pkg;
  localparam int PORT_W = 32;
  localparam int FSEL_W = 4;
  localparam int FREQ_W = 32;
  localparam int PHASE_W = 16;
  localparam int AMP_W = 16;
  localparam int AMP_LIVE_W = 12;
  localparam int SAMPLE_DIV = 24;
  localparam int DIV_W = 5;
  localparam logic [DIV_W-1:0] DIV_LAST = 5'h17;
  localparam int FIFO_DEPTH = 8;
  localparam logic [15:0] AMP_LIVE_MASK = 16'h0FFF;
  localparam logic [31:0] FREQ_RST = 32'h00000000;
  localparam logic [15:0] PHASE_RST = 16'h0000;
  localparam logic [15:0] AMP_RST = 16'h0000;

  typedef enum logic [3:0] {
    PPMM_PAR_PROG = 4'h0,
    PPMM_SER_PROG = 4'h1,
    PPMM_FREQ_FULL = 4'h2,
    PPMM_FREQ_SWAP = 4'h3,
    PPMM_PHASE_AMP = 4'h4,
    PPMM_AMP_PHASE = 4'h5,
    PPMM_FHI_AMPHI = 4'h6,
    PPMM_FHI_PHHI = 4'h7,
    PPMM_FHI_AMPLO = 4'h8,
    PPMM_FHI_PHLO = 4'h9,
    PPMM_FLO_AMPHI = 4'hA,
    PPMM_FLO_PHHI = 4'hB,
    PPMM_FLO_AMPLO = 4'hC,
    PPMM_FLO_PHLO = 4'hD,
    PPMM_UNUSED_E = 4'hE,
    PPMM_UNUSED_F = 4'hF
  } ppmm_mode_t;

  typedef struct packed {
    logic [FREQ_W-1:0] freq_tuning_word;
    logic [PHASE_W-1:0] phase_offset_word;
    logic [AMP_W-1:0] amplitude_word;
  } ppmm_params_t;

  typedef struct packed {
    logic [7:0] data_hi;
    logic [7:0] data_lo;
    logic [7:0] address;
    logic [7:0] control;
  } ppmm_par_word_t;

  typedef struct packed {
    logic serial_io_sync;
    logic serial_data_out;
    logic sdio;
    logic sclk;
    logic cs;
  } ppmm_serial_t;

  typedef struct packed {
    ppmm_mode_t mode;
    logic [PORT_W-1:0] lanes;
  } ppmm_sample_t;
endpackage
`default_nettype wire

// ### src/ppmm_fifo.sv
`default_nettype none
module ppmm_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  // Sized one bit wider than the pointers so that a full count of DEPTH is representable.
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign o_in_ready = (count != DEPTH_C);
  assign o_out_valid = (count != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_ptr];

  always_comb begin
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = (AW+1)'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = (AW+1)'(count - 1'b1);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end
endmodule
`default_nettype wire

// ### src/ppmm_rate_div.sv
`default_nettype none
module ppmm_rate_div (
  input wire logic i_clk,
  input wire logic i_nrst,
  output logic o_tick
);
  logic [ppmm_pkg::DIV_W-1:0] cnt;
  logic [ppmm_pkg::DIV_W-1:0] next_cnt;
  logic next_tick;

  always_comb begin
    next_tick = (cnt == ppmm_pkg::DIV_LAST);
    next_cnt = next_tick ? '0 : ppmm_pkg::DIV_W'(cnt + 1'b1);
  end

  // The tick is registered, so it is one cycle wide every 24 cycles.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      o_tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// ### bench/ppmm_ctrl_model.sv
`default_nettype none
module ppmm_ctrl_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_next_sel,
  input wire logic [31:0] i_next_port,
  output logic [3:0] o_func_sel,
  output logic [31:0] o_port,
  output logic o_upd
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt;
  // Lanes and select change together only on the edge before the sampling edge, so each sample sees one mode.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= 5'h00;
      o_func_sel <= 4'h0;
      o_port <= 32'h0;
      o_upd <= 1'b0;
    end else begin
      cnt <= (cnt == 5'h17) ? 5'h00 : cnt + 5'h01;
      o_upd <= (cnt == 5'h17);
      if (cnt == 5'h17) begin
        o_func_sel <= i_next_sel;
        o_port <= i_next_port;
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/ppmm_sva.sv
`default_nettype none
module ppmm_sva (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_func_sel,
  input wire logic [31:0] i_port,
  input wire logic i_amp_scale_enable,
  input wire logic i_stream_enable,
  input wire logic i_io_update,
  input wire logic o_par_valid,
  input wire logic i_par_ready,
  input wire ppmm_pkg::ppmm_par_word_t o_par_word,
  input wire logic o_serial_active,
  input wire ppmm_pkg::ppmm_params_t o_core_params,
  input wire logic o_core_load
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] p1;
  logic [31:0] p2;
  logic [3:0] s1;
  logic [3:0] s2;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      p1 <= 32'h0;
      p2 <= 32'h0;
      s1 <= 4'h0;
      s2 <= 4'h0;
    end else begin
      p1 <= i_port;
      p2 <= p1;
      s1 <= i_func_sel;
      s2 <= s1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_amp_top_zero: assert property (o_core_params.amplitude_word[15:12] == 4'h0)
    else $error("amplitude bits 15:12 not zero");
  a_par_hold: assert property (o_par_valid && !i_par_ready |=> o_par_valid && $stable(o_par_word))
    else $error("parallel word not held");
  a_par_source: assert property ($rose(o_par_valid) && !$past(o_par_valid, 2) |-> s2 == 4'h0 && o_par_word == p2)
    else $error("parallel word wrong");
  a_ser_source: assert property ($rose(o_serial_active) |-> s2 == 4'h1)
    else $error("serial active without serial select");
  a_load_cause: assert property (o_core_load |-> $past(i_stream_enable) ||
    $past(i_io_update) || $past(i_io_update, 2))
    else $error("core loaded without stream or update");
  a_core_change: assert property ($changed(o_core_params) |-> o_core_load)
    else $error("core params changed without load");
  a_amp_gate: assert property (o_core_load && !i_amp_scale_enable && !$past(i_amp_scale_enable) |-> $stable(o_core_params.amplitude_word))
    else $error("amplitude changed while scaling off");
  a_unused_quiet: assert property (o_core_load && $past(i_stream_enable) &&
    !$past(i_io_update) |-> s2 inside {[4'h2:4'hD]})
    else $error("load from non direct select");
  a_freq_full: assert property (o_core_load && i_stream_enable && s2 == 4'h2 |-> o_core_params.freq_tuning_word == p2)
    else $error("full frequency word wrong");
  a_freq_swap: assert property (o_core_load && i_stream_enable && s2 == 4'h3 |-> o_core_params.freq_tuning_word == {p2[15:0], p2[31:16]})
    else $error("swapped frequency word wrong");
  a_phase_amp: assert property (o_core_load && i_stream_enable && s2 == 4'h4 |-> o_core_params.phase_offset_word == p2[31:16])
    else $error("phase word wrong");
endmodule
bind ppmm_top ppmm_sva u_sva (.i_clk(i_clk), .i_nrst(i_nrst), .i_func_sel(i_func_sel),
  .i_port(i_port), .i_amp_scale_enable(i_amp_scale_enable), .i_stream_enable(i_stream_enable),
  .i_io_update(i_io_update), .o_par_valid(o_par_valid), .i_par_ready(i_par_ready),
  .o_par_word(o_par_word), .o_serial_active(o_serial_active), .o_core_params(o_core_params),
  .o_core_load(o_core_load));
`default_nettype wire

// ### bench/ppmm_top_tb.sv
`default_nettype none
module ppmm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, amp_en, stream, io_upd, par_rdy, upd, drop_seen, par_valid, ser_act, load, drop;
  logic [3:0] nsel, fsel;
  logic [31:0] nport, port, first, hf;
  logic [15:0] hp, ha;
  ppmm_pkg::ppmm_par_word_t par_word;
  ppmm_pkg::ppmm_serial_t ser;
  ppmm_pkg::ppmm_params_t core, ce;
  int n_errors, comparisons, cyc, nacc;
  ppmm_ctrl_model u_ctrl (.i_clk(clk), .i_nrst(nrst), .i_next_sel(nsel), .i_next_port(nport),
    .o_func_sel(fsel), .o_port(port), .o_upd(upd));
  ppmm_top DUT (.i_clk(clk), .i_nrst(nrst), .i_func_sel(fsel), .i_port(port),
    .i_amp_scale_enable(amp_en), .i_stream_enable(stream), .i_io_update(io_upd),
    .o_par_valid(par_valid), .i_par_ready(par_rdy), .o_par_word(par_word), .o_serial(ser),
    .o_serial_active(ser_act), .o_core_params(core), .o_core_load(load), .o_sample_dropped(drop));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (drop === 1'b1) drop_seen = 1'b1;
    if (par_valid === 1'b1 && par_rdy === 1'b1) nacc++;
    if (cyc == 5000) begin
      n_errors++;
      test_done();
    end
  end
  task test_done();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task cmp_par(input ppmm_pkg::ppmm_params_t exp);
    comparisons++;
    if (core !== exp) begin
      n_errors++;
      $display("unexpected at %0t core %h expected %h", $time, core, exp);
    end
  endtask
  task cmp_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task copy();
    ce.freq_tuning_word = hf;
    ce.phase_offset_word = hp;
    if (amp_en) ce.amplitude_word = ha & ppmm_pkg::AMP_LIVE_MASK;
  endtask
  // The values are on the pins after one update and captured at the next one.
  task send(input logic [3:0] s, input logic [31:0] p, input logic a);
    @(posedge clk) begin
      nsel <= s;
      nport <= p;
      amp_en <= a;
    end
    @(posedge clk iff upd === 1'b1);
    @(posedge clk iff upd === 1'b1);
    @(posedge clk);
    #1;
    case (s)
      4'h2: hf = p;
      4'h3: hf = {p[15:0], p[31:16]};
      4'h4: {hp, ha[11:0]} = {p[31:16], p[11:0]};
      4'h5: {ha[11:0], hp} = {p[27:16], p[15:0]};
      default: ;
    endcase
    if (s inside {[4'h6:4'h9]}) hf[31:8] = p[31:8];
    if (s inside {[4'hA:4'hD]}) hf[23:0] = p[31:8];
    if (s inside {[4'h6:4'hD]}) begin
      case (s[1:0])
        2'h2: ha[15:8] = p[7:0];
        2'h3: hp[15:8] = p[7:0];
        2'h0: ha[7:0] = p[7:0];
        default: hp[7:0] = p[7:0];
      endcase
    end
    if (stream && s inside {[4'h2:4'hD]}) copy();
    cmp_par(ce);
    cmp_val(32'(load), 32'(stream && s inside {[4'h2:4'hD]}));
  endtask
  initial begin
    {nrst, io_upd, drop_seen, nport, hf, hp, ha, ce} = '0;
    {amp_en, stream, par_rdy} = 3'h7;
    nsel = 4'hE;
    {n_errors, comparisons, cyc, nacc} = '0;
    first = $urandom(32'h91DB);
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 28; i++) send(4'(2 + i % 14), $urandom(), i % 5 != 0);
    @(posedge clk) stream <= 1'b0;
    send(4'h2, $urandom(), 1'b1);
    send(4'h4, $urandom(), 1'b1);
    @(posedge clk) io_upd <= 1'b1;
    @(posedge clk) io_upd <= 1'b0;
    @(posedge clk);
    #1;
    copy();
    cmp_par(ce);
    @(posedge clk) stream <= 1'b1;
    send(4'h1, first, 1'b1);
    cmp_val(32'(ser), 32'(first[4:0]));
    cmp_val(32'(ser_act), 32'h1);
    @(posedge clk) par_rdy <= 1'b0;
    nacc = 0;
    for (int i = 0; i < 10; i++) send(4'h0, (i == 0) ? first : $urandom(), 1'b1);
    cmp_val(32'(drop_seen), 32'h1);
    cmp_val(par_word, first);
    @(posedge clk) par_rdy <= 1'b1;
    // The held word plus a full FIFO drain before the next sample period brings a new word.
    repeat (20) @(posedge clk);
    cmp_val(32'(nacc), 32'(1 + ppmm_pkg::FIFO_DEPTH));
    cmp_val(32'(par_valid), 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
